// *** verilog/eccr_pkg.sv ***
`default_nettype none
package eccr_pkg;
   localparam logic [15:0] ADDR_REV = 16'h7f06;
   localparam logic [15:0] ADDR_ID = 16'h7f07;
   localparam logic [15:0] ADDR_OUTEN = 16'h7f3e;
   localparam logic [15:0] ADDR_CFG0 = 16'h7ff4;
   localparam logic [15:0] ADDR_AUXDATA = 16'h7ffa;
   localparam logic [15:0] ADDR_HOSTLATCH = 16'h7ffd;
   localparam logic [15:0] ADDR_OUTDATA = 16'h7ff1;
   localparam logic [15:0] ADDR_GATE_CLR = 16'h7ffe;
   localparam logic [15:0] ADDR_GATE_SET = 16'h7fff;
   localparam logic [15:0] SCRATCH_RAM_BASE = 16'h7d00;
   localparam logic [15:0] SCRATCH_ROM_BASE = 16'h0000;
   localparam logic [7:0] CFG0_RESET = 8'h00;
   localparam logic [7:0] CFG0_WMASK = 8'hbf;
   localparam logic [7:0] HOST_MEM_LOAD = 8'h07;
   localparam int CFG_SLEEP = 0;
   localparam int CFG_GATE_ASSIST = 1;
   localparam int CFG_HOST_SRC = 2;
   localparam int CFG_MEM_MAP = 3;
   localparam int CFG_PS_TWO_ENGINE_SELECT = 4;
   localparam int CFG_IRQ_GATE = 5;
   localparam int CFG_AUX_HW = 7;
   localparam int OE_CLK32 = 0;
   localparam int OE_RST = 1;
   localparam int OE_MAIN_SUPPLY_OK_PIN = 2;
   localparam int OE_OVRD = 3;
   localparam int FORCE_NS = 100;
   localparam int CLK_NS = 4;
   localparam int FORCE_CYC = FORCE_NS / CLK_NS;
   typedef enum logic [1:0] {ECCR_RUN, ECCR_COUNT, ECCR_HANDED} eccr_state_t;
endpackage
`default_nettype wire

// *** verilog/eccr_regs.sv ***
// Functional notes
// [RL1] hardwired revision code, read only
// [RL2] read-only part identifier register
// [RL3] aux hw bit: data write sets aux flag
// [RL4] gate bit routes full flags to irqs
// [RL5] firmware keeps gate stable while full
// [RL6] memory map bit moves scratch area
// [RL7] host flag source: latch or data write
// [RL8] engine select picks ps/2 logic
// [RL9] assist bit gives firmware gatea20
// [RL10] power control bit picks idle/sleep
// [RL11] sleep select cleared by wake, reset
// [RL12] output enable reset values per plane
// [RL13] power fail forces reset bit, locked
// [RL14] power good readback bit
// [RL15] override drives reset pin directly
// [RL16] clearing reset bit starts stop count
// [RL17] count zero releases pin, stops clock
// [RL18] clock output bit gates slow clock
// [RL19] power fail beats high, low priority
// [RL20] wake trigger: fixed, select, either
// [RL21] reset pin undriven without main plane
// [RL22] clear sets stop flag, host mem bits
// [RL23] reserved bits read zero
`default_nettype none
module eccr_regs
   import eccr_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h01, // arbitrary value
   parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
   parameter int WAKE_N = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic main_plane_nrst,
   input wire logic main_plane_present,
   input wire logic [15:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic main_supply_ok_pin,
   input wire logic host_gate_event,
   input wire logic host_gate_value,
   input wire logic obf_status,
   input wire logic [7:0] stop_count_value,
   input wire logic stop_count_zero,
   output logic stop_count_load,
   input wire logic slow_clock_in,
   input wire logic core_power_control_set,
   input wire logic [WAKE_N-1:0] wake_in,
   input wire logic [WAKE_N-1:0] wake_edge_sel,
   input wire logic [WAKE_N-1:0] wake_either,
   input wire logic [WAKE_N-1:0] wake_fixed,
   input wire logic [WAKE_N-1:0] wake_mask,
   input wire logic pfi_req,
   input wire logic pfi_en,
   input wire logic hi_req,
   input wire logic lo_req,
   output logic [1:0] irq_grant,
   output logic wake_event,
   output logic keyboard_irq_line,
   output logic mouse_irq_line,
   output logic aux_output_full_flag,
   output logic host_output_full_flag,
   output logic scratch_map_rom,
   output logic [15:0] scratch_base,
   output logic ps_two_engine_select,
   output logic hardware_ps_two_channels,
   output logic gate_a20,
   output logic enter_idle,
   output logic enter_sleep,
   output logic controller_stop_clock_flag,
   output logic [7:0] host_memory_select,
   output logic internal_reset,
   output logic system_reset_pin,
   output logic system_reset_pin_n_oe,
   output logic slow_clock_output_pin,
   output logic controller_clock_stop,
   output logic flash_to_host
);
   // -------------------------------------------------
   // reset and pin synchronisers
   // -------------------------------------------------
   logic rst_s1, rst_n;
   logic pg_s1, pg_s2, sc_s1, sc_s2, mp_s1, mp_s2;
   logic [WAKE_N-1:0] wk_s1, wk_s2, wk_d;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pg_s1 <= 1'b0;
         pg_s2 <= 1'b0;
         sc_s1 <= 1'b0;
         sc_s2 <= 1'b0;
         mp_s1 <= 1'b0;
         mp_s2 <= 1'b0;
         wk_s1 <= '0;
         wk_s2 <= '0;
         wk_d <= '0;
      end else begin
         pg_s1 <= main_supply_ok_pin;
         pg_s2 <= pg_s1;
         sc_s1 <= slow_clock_in;
         sc_s2 <= sc_s1;
         mp_s1 <= main_plane_present;
         mp_s2 <= mp_s1;
         wk_s1 <= wake_in;
         wk_s2 <= wk_s1;
         wk_d <= wk_s2;
      end
   end

   // -------------------------------------------------
   // wake triggers and priority
   // -------------------------------------------------
   logic [WAKE_N-1:0] rise, fall, trig;
   always_comb begin
      rise = wk_s2 & ~wk_d;
      fall = ~wk_s2 & wk_d;
      for (int i = 0; i < WAKE_N; i++) begin
         if (wake_either[i]) begin
            trig[i] = rise[i] | fall[i]; // [RL20]
         end else if (wake_fixed[i]) begin
            trig[i] = fall[i]; // [RL20]
         end else begin
            trig[i] = wake_edge_sel[i] ? rise[i] : fall[i]; // [RL20]
         end
      end
      wake_event = |(trig & ~wake_mask);
      // 0 none, 1 low, 2 high, 3 power fail
      if (pfi_req && pfi_en) begin
         irq_grant = 2'd3; // [RL19]
      end else if (hi_req) begin
         irq_grant = 2'd2; // [RL19]
      end else if (lo_req) begin
         irq_grant = 2'd1; // [RL19]
      end else begin
         irq_grant = 2'd0;
      end
   end

   // -------------------------------------------------
   // register state
   // -------------------------------------------------
   logic [7:0] cfg_reg, cfg_next;
   logic aux_reg, aux_next, host_reg, host_next, latch_reg, latch_next;
   logic gate_reg, gate_next, fw_gate_reg, fw_gate_next;
   logic rst_bit_reg, rst_bit_next, ovrd_reg, ovrd_next;
   logic clk32_reg, clk32_next, stpf_reg, stpf_next;
   logic [7:0] host_memory_select_reg, host_memory_select_next;
   logic [4:0] force_reg, force_next;
   eccr_state_t st_reg, st_next;
   logic wr_cfg, wr_oe, rst_fall;
   always_comb begin
      wr_cfg = wr && addr == ADDR_CFG0;
      wr_oe = wr && addr == ADDR_OUTEN;
      cfg_next = cfg_reg;
      aux_next = aux_reg;
      host_next = host_reg;
      latch_next = latch_reg;
      gate_next = gate_reg;
      fw_gate_next = fw_gate_reg;
      rst_bit_next = rst_bit_reg;
      ovrd_next = ovrd_reg;
      clk32_next = clk32_reg;
      stpf_next = stpf_reg;
      host_memory_select_next = host_memory_select_reg;
      force_next = force_reg;
      st_next = st_reg;
      stop_count_load = 1'b0;
      if (wr_cfg) begin
         cfg_next = wdata & CFG0_WMASK; // [RL23]
      end
      if (wake_event) begin
         cfg_next[CFG_SLEEP] = 1'b0; // [RL11]
      end
      // aux flag: hardware set wins over a same-cycle firmware clear
      if (wr && addr == ADDR_AUXDATA && cfg_reg[CFG_AUX_HW]) begin
         aux_next = 1'b1; // [RL3]
      end else if (wr && addr == ADDR_AUXDATA) begin
         aux_next = wdata[0]; // [RL3]
      end
      if (wr && addr == ADDR_HOSTLATCH) begin
         latch_next = wdata[0];
      end
      if (wr && addr == ADDR_OUTDATA) begin
         host_next = 1'b1;
      end else if (rd && addr == ADDR_OUTDATA) begin
         host_next = 1'b0;
      end
      if (wr && addr == ADDR_GATE_CLR) begin
         gate_next = 1'b0; // [RL9]
      end else if (wr && addr == ADDR_GATE_SET) begin
         gate_next = 1'b1; // [RL9]
      end else if (host_gate_event) begin
         gate_next = host_gate_value; // [RL9]
      end
      if (wr_cfg) begin
         fw_gate_next = wdata[CFG_GATE_ASSIST] ? gate_reg : fw_gate_reg;
      end
      rst_fall = 1'b0;
      if (wr_oe) begin
         ovrd_next = wdata[OE_OVRD];
         clk32_next = wdata[OE_CLK32]; // [RL18]
         if (pg_s2 && force_reg == 5'd0) begin
            rst_bit_next = wdata[OE_RST]; // [RL13]
            rst_fall = rst_bit_reg && !wdata[OE_RST];
         end
      end
      // power fail: force and hold the bit at once, count force_reg up to FORCE_CYC - 1
      if (!pg_s2) begin
         if (force_reg < 5'(FORCE_CYC - 1)) begin
            force_next = force_reg + 5'd1;
         end
         rst_bit_next = 1'b1; // [RL13]
         st_next = ECCR_RUN;
      end else begin
         force_next = 5'd0;
      end
      if (rst_fall && !ovrd_next) begin
         stpf_next = 1'b1; // [RL16] [RL22]
         host_memory_select_next = HOST_MEM_LOAD; // [RL16] [RL22]
         stop_count_load = 1'b1; // [RL16]
         st_next = ECCR_COUNT;
      end
      unique case (st_reg)
         ECCR_RUN: begin
         end
         ECCR_COUNT: begin
            if (stop_count_zero) begin
               st_next = ECCR_HANDED; // [RL17]
            end
         end
         ECCR_HANDED: begin
            if (rst_bit_next) begin
               st_next = ECCR_RUN;
            end
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= CFG0_RESET; // [RL11]
         aux_reg <= 1'b0;
         host_reg <= 1'b0;
         latch_reg <= 1'b0;
         gate_reg <= 1'b0;
         fw_gate_reg <= 1'b0;
         rst_bit_reg <= 1'b1; // [RL12]
         ovrd_reg <= 1'b0; // [RL12]
         clk32_reg <= 1'b0; // [RL12] [RL18]
         stpf_reg <= 1'b0;
         host_memory_select_reg <= 8'h00;
         force_reg <= 5'd0;
         st_reg <= ECCR_RUN;
      end else if (!main_plane_nrst) begin
         // main plane reset keeps the reserved-x bits as they are
         rst_bit_reg <= 1'b1; // [RL12]
         ovrd_reg <= 1'b0; // [RL12]
         st_reg <= ECCR_RUN;
      end else begin
         cfg_reg <= cfg_next;
         aux_reg <= aux_next;
         host_reg <= host_next;
         latch_reg <= latch_next;
         gate_reg <= gate_next;
         fw_gate_reg <= fw_gate_next;
         rst_bit_reg <= rst_bit_next;
         ovrd_reg <= ovrd_next;
         clk32_reg <= clk32_next;
         stpf_reg <= stpf_next;
         host_memory_select_reg <= host_memory_select_next;
         force_reg <= force_next;
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------
   // outputs and read mux
   // -------------------------------------------------
   always_comb begin
      aux_output_full_flag = aux_reg;
      host_output_full_flag = cfg_reg[CFG_HOST_SRC] ? latch_reg
                                                    : host_reg; // [RL7]
      keyboard_irq_line = cfg_reg[CFG_IRQ_GATE]
                          & host_output_full_flag; // [RL4]
      mouse_irq_line = cfg_reg[CFG_IRQ_GATE] & aux_reg; // [RL4]
      scratch_map_rom = cfg_reg[CFG_MEM_MAP]; // [RL6]
      scratch_base = cfg_reg[CFG_MEM_MAP] ? SCRATCH_ROM_BASE
                                          : SCRATCH_RAM_BASE; // [RL6]
      ps_two_engine_select = !cfg_reg[CFG_PS_TWO_ENGINE_SELECT]; // [RL8]
      hardware_ps_two_channels = cfg_reg[CFG_PS_TWO_ENGINE_SELECT]; // [RL8]
      gate_a20 = cfg_reg[CFG_GATE_ASSIST] ? fw_gate_reg : gate_reg; // [RL9]
      enter_idle = core_power_control_set & !cfg_reg[CFG_SLEEP]; // [RL10]
      enter_sleep = core_power_control_set & cfg_reg[CFG_SLEEP]; // [RL10]
      controller_stop_clock_flag = stpf_reg;
      host_memory_select = host_memory_select_reg;
      internal_reset = ovrd_reg ? rst_bit_reg
                                : (st_reg != ECCR_HANDED); // [RL15]
      system_reset_pin = !internal_reset; // [RL15] [RL17]
      system_reset_pin_n_oe = !mp_s2; // [RL21]
      slow_clock_output_pin = clk32_reg & sc_s2; // [RL18]
      controller_clock_stop = !ovrd_reg && st_reg == ECCR_HANDED; // [RL17]
      flash_to_host = controller_clock_stop; // [RL17]
      unique case (addr)
         ADDR_REV: rdata = REVISION; // [RL1]
         ADDR_ID: rdata = PART_ID; // [RL2]
         ADDR_CFG0: rdata = cfg_reg; // [RL23]
         ADDR_OUTEN: rdata = {4'h0, ovrd_reg, pg_s2, rst_bit_reg,
                              clk32_reg}; // [RL14] [RL23]
         default: rdata = 8'h00;
      endcase
   end
   logic unused;
   assign unused = obf_status ^ (|stop_count_value) ^ st_next[0];
endmodule
`default_nettype wire

// *** sim/eccr_stop_model.sv ***
`default_nettype none
module eccr_stop_model #(
   parameter int COUNT = 6
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   output logic zero
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_reg;
   // ------------------------------
   // firmware stop counter
   // ------------------------------
   // count is never zero when loaded, zero stays up until the next load
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 0;
         zero <= 1'b0;
      end else if (load) begin
         cnt_reg <= COUNT;
         zero <= 1'b0;
      end else if (cnt_reg > 1) begin
         cnt_reg <= cnt_reg - 1;
      end else if (cnt_reg == 1) begin
         cnt_reg <= 0;
         zero <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** sim/eccr_regs_sva.sv ***
`default_nettype none
module eccr_regs_sva
   import eccr_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h01, // arbitrary value
   parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] addr,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic main_supply_ok_pin,
   input wire logic main_plane_present,
   input wire logic stop_count_zero,
   input wire logic stop_count_load,
   input wire logic pfi_req,
   input wire logic pfi_en,
   input wire logic [1:0] irq_grant,
   input wire logic keyboard_irq_line,
   input wire logic mouse_irq_line,
   input wire logic aux_output_full_flag,
   input wire logic host_output_full_flag,
   input wire logic controller_stop_clock_flag,
   input wire logic [7:0] host_memory_select,
   input wire logic internal_reset,
   input wire logic system_reset_pin,
   input wire logic system_reset_pin_n_oe,
   input wire logic controller_clock_stop,
   input wire logic flash_to_host,
   input wire logic wake_event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------------------------------
   // config shadow
   // ------------------------------
   // wake events clear the sleep select bit in the shadow as well
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   always_comb begin
      cfg_next = cfg_reg;
      if (wr && addr == ADDR_CFG0) begin
         cfg_next = wdata & CFG0_WMASK;
      end
      if (wake_event) begin
         cfg_next[CFG_SLEEP] = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_reg <= CFG0_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end
   // ------------------------------
   // properties
   // ------------------------------
   sequence s_stop_armed;
      stop_count_load;
   endsequence
   sequence s_handed;
      system_reset_pin && controller_clock_stop && flash_to_host;
   endsequence
   a_rev_read:
      assert property (addr == ADDR_REV |-> rdata == REVISION)
      else $error("revision read wrong");
   a_id_read:
      assert property (addr == ADDR_ID |-> rdata == PART_ID)
      else $error("part id read wrong");
   a_cfg_readback:
      assert property (addr == ADDR_CFG0 |-> rdata == cfg_reg)
      else $error("config readback wrong");
   a_irq_gate_route:
      assert property (keyboard_irq_line ==
         (cfg_reg[CFG_IRQ_GATE] && host_output_full_flag) &&
         mouse_irq_line == (cfg_reg[CFG_IRQ_GATE] && aux_output_full_flag))
      else $error("irq gating wrong");
   a_power_fail_force:
      assert property (!main_supply_ok_pin [*4] |-> internal_reset)
      else $error("reset not forced on power fail");
   a_pin_undriven:
      assert property (!main_plane_present [*3] |-> system_reset_pin_n_oe)
      else $error("reset pin driven without main plane");
   a_pfi_first:
      assert property (pfi_req && pfi_en |-> ##[0:1] irq_grant == 2'b11)
      else $error("power fail not granted first");
   a_stop_start:
      assert property (s_stop_armed |-> ##[0:1] (controller_stop_clock_flag
         && host_memory_select == HOST_MEM_LOAD))
      else $error("stop start state wrong");
   a_stop_handover:
      assert property ($rose(stop_count_zero) |-> ##1 s_handed)
      else $error("handover missing after count");
endmodule
bind eccr_regs eccr_regs_sva #(.REVISION(REVISION), .PART_ID(PART_ID))
   i_eccr_regs_sva (.*);
`default_nettype wire

// *** sim/eccr_regs_tb.sv ***
`default_nettype none
module eccr_regs_tb
   import eccr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] REV_VAL = 8'h3c; // arbitrary value
   localparam logic [7:0] ID_VAL = 8'hc5; // arbitrary value
   logic clk = 0, nrst = 0, main_plane_nrst = 1, main_plane_present = 1;
   logic [15:0] addr = 16'h0000, scratch_base;
   logic wr = 0, rd = 0, main_supply_ok_pin = 1, host_gate_event = 0;
   logic [7:0] wdata = 8'h00, rdata, host_memory_select, v;
   logic host_gate_value = 0, stop_count_zero, stop_count_load;
   logic slow_clock_in = 0, core_power_control_set = 0, gate_a20;
   logic [3:0] wsel, weither, wfixed, wmask, r;
   logic [3:0] wk = 4'h0;
   logic pfi_req = 0, pfi_en = 0, hi_req = 0, lo_req = 0, enter_sleep;
   logic [1:0] irq_grant;
   logic keyboard_irq_line, mouse_irq_line, enter_idle, system_reset_pin;
   logic hardware_ps_two_channels, controller_stop_clock_flag;
   logic system_reset_pin_n_oe, slow_clock_output_pin, controller_clock_stop;
   logic flash_to_host;
   int seed, mismatches = 0, total_checks = 0, cycles = 0;
   eccr_regs #(.REVISION(REV_VAL), .PART_ID(ID_VAL), .WAKE_N(4)) i_eccr_regs (
      .clk, .nrst, .main_plane_nrst, .main_plane_present, .addr, .wr, .rd,
      .wdata, .rdata, .main_supply_ok_pin, .host_gate_event, .host_gate_value,
      .obf_status(1'b0), .stop_count_value(8'h06), .stop_count_zero,
      .stop_count_load, .slow_clock_in, .core_power_control_set,
      .wake_in(wk), .wake_edge_sel(wsel), .wake_either(weither),
      .wake_fixed(wfixed), .wake_mask(wmask), .pfi_req, .pfi_en, .hi_req,
      .lo_req, .irq_grant, .wake_event(), .keyboard_irq_line, .mouse_irq_line,
      .aux_output_full_flag(), .host_output_full_flag(), .scratch_map_rom(),
      .scratch_base, .ps_two_engine_select(), .hardware_ps_two_channels,
      .gate_a20, .enter_idle, .enter_sleep, .controller_stop_clock_flag,
      .host_memory_select, .internal_reset(), .system_reset_pin,
      .system_reset_pin_n_oe, .slow_clock_output_pin, .controller_clock_stop,
      .flash_to_host);
   eccr_stop_model #(.COUNT(6)) i_eccr_stop_model (.clk, .nrst,
      .load(stop_count_load), .zero(stop_count_zero));
   // ------------------------------
   // clock, timeout, helpers
   // ------------------------------
   always #2 clk = ~clk;
   always #16 slow_clock_in = ~slow_clock_in;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   function automatic logic [1:0] exp_grant(logic [3:0] q);
      return (q[3] && q[2]) ? 2'b11 : q[1] ? 2'b10 : q[0] ? 2'b01 : 2'b00;
   endfunction
   function automatic logic [15:0] exp_base(logic [7:0] c);
      return c[CFG_MEM_MAP] ? SCRATCH_ROM_BASE : SCRATCH_RAM_BASE;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd8(input logic [15:0] a, input logic [7:0] m,
         input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      #1;
      chk(16'(rdata & m), 16'(e));
      cyc(1);
      rd = 1'b0;
      cyc(1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      seed = 32'h36e06d8b;
      {wsel, weither, wfixed, wmask} = 16'($random(seed));
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      cyc(3);
      rd8(ADDR_CFG0, 8'hff, CFG0_RESET);
      rd8(ADDR_OUTEN, 8'hff, 8'h06);
      wr8(ADDR_REV, 8'hff);
      wr8(16'h7f08, 8'hff);
      rd8(ADDR_REV, 8'hff, REV_VAL);
      rd8(ADDR_ID, 8'hff, ID_VAL);
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         wr8(ADDR_CFG0, v);
         rd8(ADDR_CFG0, 8'hff, v & 8'hbf);
         chk(scratch_base, exp_base(v));
         chk(16'(hardware_ps_two_channels), 16'(v[CFG_PS_TWO_ENGINE_SELECT]));
         core_power_control_set = 1'b1;
         #1;
         chk(16'({enter_sleep, enter_idle}), 16'({v[0], !v[0]}));
         cyc(1);
         core_power_control_set = 1'b0;
      end
      weither = 4'hf;
      wmask = 4'h0;
      wr8(ADDR_CFG0, 8'h01);
      wk = 4'h1;
      cyc(5);
      rd8(ADDR_CFG0, 8'hff, 8'h00);
      wk = 4'h0;
      cyc(5);
      $display("test done: config");
      // flags shown only while the gate is set, host flags cleared before gate changes, aux flag still set when the gate is cleared
      wr8(ADDR_CFG0, 8'h20);
      wr8(ADDR_OUTDATA, 8'h5a);
      chk(16'(keyboard_irq_line), 16'h0001);
      rd8(ADDR_OUTDATA, 8'h00, 8'h00);
      chk(16'(keyboard_irq_line), 16'h0000);
      wr8(ADDR_CFG0, 8'h24);
      wr8(ADDR_HOSTLATCH, 8'h01);
      chk(16'(keyboard_irq_line), 16'h0001);
      wr8(ADDR_HOSTLATCH, 8'h00);
      wr8(ADDR_CFG0, 8'ha0);
      wr8(ADDR_AUXDATA, 8'h33);
      chk(16'(mouse_irq_line), 16'h0001);
      wr8(ADDR_CFG0, 8'h00);
      host_gate_event = 1'b1;
      host_gate_value = 1'b1;
      cyc(1);
      host_gate_event = 1'b0;
      chk(16'(gate_a20), 16'h0001);
      wr8(ADDR_GATE_CLR, 8'h00);
      chk(16'(gate_a20), 16'h0000);
      for (int i = 0; i < 8; i++) begin
         r = 4'($random(seed));
         {pfi_req, pfi_en, hi_req, lo_req} = r;
         cyc(2);
         chk(16'(irq_grant), 16'(exp_grant(r)));
      end
      $display("test done: flags");
      wr8(ADDR_OUTEN, 8'h0a);
      chk(16'(system_reset_pin), 16'h0000);
      wr8(ADDR_OUTEN, 8'h08);
      chk(16'({system_reset_pin, controller_stop_clock_flag}), 16'h2);
      chk(16'(slow_clock_output_pin), 16'h0000);
      main_supply_ok_pin = 1'b0;
      cyc(4);
      rd8(ADDR_OUTEN, 8'h06, 8'h02);
      wr8(ADDR_OUTEN, 8'h08);
      rd8(ADDR_OUTEN, 8'h02, 8'h02);
      main_supply_ok_pin = 1'b1;
      main_plane_present = 1'b0;
      cyc(40);
      rd8(ADDR_OUTEN, 8'h04, 8'h04);
      chk(16'(system_reset_pin_n_oe), 16'h0001);
      main_plane_present = 1'b1;
      wr8(ADDR_OUTEN, 8'h09);
      main_plane_nrst = 1'b0;
      cyc(2);
      main_plane_nrst = 1'b1;
      cyc(2);
      rd8(ADDR_OUTEN, 8'hff, 8'h07);
      $display("test done: reset output");
      wr8(ADDR_OUTEN, 8'h00);
      cyc(1);
      chk({8'(controller_stop_clock_flag), host_memory_select}, 16'h0107);
      for (int k = 0; k < 40 && controller_clock_stop !== 1'b1; k++) cyc(1);
      chk(16'({system_reset_pin, controller_clock_stop, flash_to_host}), 16'h7);
      $display("test done: stop sequence");
      stop_test();
   end
endmodule
`default_nettype wire
